//--- verilog/mmss_pkg.sv
// mmss_pkg: constants for the management-mode state-save logic
// assumes: used by mmss_core and mmss_core_tb, nothing imported
package mmss_pkg;
    // ------------------------------------------------------------
    // state-save offsets
    // ------------------------------------------------------------
    localparam logic [15:0] OFS_REVISION = 16'h7efc;
    localparam logic [15:0] OFS_IO_RESTART = 16'h7f00;
    localparam logic [15:0] OFS_HALT_RESTART = 16'h7f02;
    localparam logic [15:0] OFS_IO_MEM_ADDR = 16'h7fa0;
    localparam logic [15:0] OFS_IO_STATE = 16'h7fa4;
    // ------------------------------------------------------------
    // field positions in the trapped i/o state word and the revision word
    // ------------------------------------------------------------
    localparam int POS_VALID = 0;
    localparam int POS_LEN_LO = 1;
    localparam int POS_TYPE_LO = 4;
    localparam int POS_PORT_LO = 16;
    localparam int POS_IO_RESTART_FEAT = 16;
    localparam int POS_RELOC_FEAT = 17;
    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [2:0] LEN_BYTE = 3'h1;
    localparam logic [2:0] LEN_WORD = 3'h2;
    localparam logic [2:0] LEN_DWORD = 3'h4;
    localparam logic [3:0] TYP_IN_IMM = 4'h9;
    localparam logic [3:0] TYP_IN_DX = 4'h1;
    localparam logic [3:0] TYP_OUT_IMM = 4'h8;
    localparam logic [3:0] TYP_OUT_DX = 4'h0;
    localparam logic [3:0] TYP_INS = 4'h3;
    localparam logic [3:0] TYP_OUTS = 4'h2;
    localparam logic [3:0] TYP_REP_INS = 4'h7;
    localparam logic [3:0] TYP_REP_OUTS = 4'h6;
    localparam logic [7:0] IO_RESTART_NONE = 8'h00;
    localparam logic [7:0] IO_RESTART_REDO = 8'hff;
    // ------------------------------------------------------------
    // exit resume targets
    // ------------------------------------------------------------
    localparam logic [1:0] RES_NORMAL = 2'h0;
    localparam logic [1:0] RES_HALT_AGAIN = 2'h1;
    localparam logic [1:0] RES_AFTER_HALT = 2'h2;
    localparam logic [1:0] RES_IO_REDO = 2'h3;
endpackage : mmss_pkg

//--- verilog/mmss_nmi_gate.sv
// mmss_nmi_gate: nmi blocking and single-request latch
// assumes: one clock, nmi request a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module mmss_nmi_gate (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // events
    input wire logic i_enter,
    input wire logic i_resume,
    input wire logic i_intr_return,
    input wire logic i_nmi_req,
    input wire logic i_nmi_ack,
    input wire logic i_in_nmi_handler,
    input wire logic i_in_mgmt,
    // status
    output logic o_nmi_blocked,
    output logic o_nmi_take
);
    typedef struct packed {
        logic blocked;
        logic pending;
        logic blocked_before;
    } mmss_nmi_st_t;
    mmss_nmi_st_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (i_nmi_ack) begin
            st_nxt.pending = 1'b0;
            st_nxt.blocked = 1'b1;
        end
        if (i_nmi_req) begin
            st_nxt.pending = 1'b1;
        end
        if (i_enter) begin
            st_nxt.blocked_before = st_r.blocked & ~i_in_nmi_handler;
            st_nxt.blocked = 1'b1;
        end else if (i_resume) begin
            st_nxt.blocked = st_r.blocked_before;
        end else if (i_intr_return && i_in_mgmt) begin
            st_nxt.blocked = 1'b0;
        end else if (i_intr_return) begin
            st_nxt.blocked = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= '0;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_nmi_blocked = st_r.blocked;
    assign o_nmi_take = st_r.pending & ~st_r.blocked;

    a_nmi_blocked_entry: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && i_enter |=> o_nmi_blocked)
        else $error("nmi not blocked after entry");
    a_nmi_latched_once: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && i_nmi_req && !i_enter |=> st_r.pending)
        else $error("nmi request not latched");
    a_nmi_intr_return_instr_unblock: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && i_intr_return && i_in_mgmt && !i_enter && !i_resume |=> !o_nmi_blocked)
        else $error("return instruction did not unblock nmi");
    a_nmi_keep_blocked: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && i_resume && !i_enter |=> o_nmi_blocked == $past(st_r.blocked_before))
        else $error("nmi blocking not restored on resume");
    a_nmi_handler_entry: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && i_enter && i_in_nmi_handler |=> !st_r.blocked_before)
        else $error("nmi handler blocking kept across entry");
    c_nmi_held: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        o_nmi_blocked && st_r.pending ##[1:20] o_nmi_take);
endmodule : mmss_nmi_gate
`default_nettype wire

//--- verilog/mmss_core.sv
// mmss_core: management-mode entry/exit state-save bookkeeping
// assumes: core pulses entry and resume strobes, handler accesses state-save fields
// through the documented offsets on a simple synchronous save-area port
`timescale 1ns/100ps
`default_nettype none
module mmss_core #(
    parameter logic [15:0] BASE_VERSION = 16'h0001, // arbitrary value
    parameter logic [15:0] REV_THRESHOLD = 16'h0001, // arbitrary value
    parameter bit HAS_IO_RESTART = 1'b1,
    parameter bit HAS_RELOC = 1'b1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // core events
    input wire logic i_mgmt_irq_take,
    input wire logic i_resume_instr,
    input wire logic i_intr_return_instr,
    input wire logic i_halt_instr,
    input wire logic i_maskable_irq,
    input wire logic i_halted,
    input wire logic i_in_nmi_handler,
    input wire logic i_nmi_req,
    input wire logic i_nmi_ack,
    // last retired i/o instruction
    input wire logic i_io_done,
    input wire logic [15:0] i_io_port,
    input wire logic [3:0] i_io_type,
    input wire logic [2:0] i_io_len,
    input wire logic [31:0] i_io_mem_addr,
    // save-area port
    input wire logic i_sa_wr,
    input wire logic i_sa_rd,
    input wire logic [15:0] i_sa_addr,
    input wire logic [31:0] i_sa_wdata,
    output logic [31:0] o_sa_rdata,
    // status
    output logic o_in_mgmt,
    output logic o_halted_state,
    output logic o_halt_fetch,
    output logic [1:0] o_resume_target,
    output logic o_resume_strobe,
    output logic o_nmi_blocked,
    output logic o_nmi_take
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_RUN, ST_MGMT, ST_MGMT_HALT} mmss_mode_t;
    typedef struct packed {
        mmss_mode_t mode;
        logic io_last;
        logic [15:0] io_port;
        logic [3:0] io_type;
        logic [2:0] io_len;
        logic [31:0] io_addr;
        logic [31:0] io_state;
        logic [31:0] io_mem;
        logic [31:0] rev;
        logic halt_entry;
        logic halt_flag;
        logic [7:0] io_restart;
        logic [31:0] rdata;
        logic [1:0] target;
        logic resume;
        logic halt_fetch;
    } mmss_st_t;
    mmss_st_t st_r, st_nxt;
    logic io_fields_ok;
    logic [31:0] rev_word;
    logic enter;
    logic resume;

    assign io_fields_ok = (BASE_VERSION >= REV_THRESHOLD);
    assign enter = i_mgmt_irq_take && (st_r.mode == ST_RUN);
    assign resume = i_resume_instr && (st_r.mode == ST_MGMT);

    always_comb begin
        rev_word = 32'h0;
        rev_word[15:0] = BASE_VERSION;
        rev_word[mmss_pkg::POS_IO_RESTART_FEAT] = HAS_IO_RESTART;
        rev_word[mmss_pkg::POS_RELOC_FEAT] = HAS_RELOC;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.resume = 1'b0;
        st_nxt.halt_fetch = 1'b0;
        if (i_io_done) begin
            st_nxt.io_last = 1'b1;
            st_nxt.io_port = i_io_port;
            st_nxt.io_type = i_io_type;
            st_nxt.io_len = i_io_len;
            st_nxt.io_addr = i_io_mem_addr;
        end else if (st_r.mode == ST_RUN && !i_mgmt_irq_take) begin
            st_nxt.io_last = 1'b0;
        end
        case (st_r.mode)
            ST_RUN: begin
                if (enter) begin
                    st_nxt.mode = ST_MGMT;
                    st_nxt.rev = rev_word;
                    st_nxt.halt_entry = i_halted;
                    st_nxt.halt_flag = i_halted;
                    st_nxt.io_restart = mmss_pkg::IO_RESTART_NONE;
                    st_nxt.io_state = 32'h0;
                    st_nxt.io_mem = 32'h0;
                    if (io_fields_ok && st_r.io_last) begin
                        // asynchronous requests right after i/o land here too
                        st_nxt.io_state[mmss_pkg::POS_VALID] = 1'b1;
                        st_nxt.io_state[31:mmss_pkg::POS_PORT_LO] = st_r.io_port;
                        st_nxt.io_state[7:mmss_pkg::POS_TYPE_LO] = st_r.io_type;
                        st_nxt.io_state[3:mmss_pkg::POS_LEN_LO] = st_r.io_len;
                        st_nxt.io_mem = st_r.io_addr;
                    end
                end
            end
            ST_MGMT: begin
                if (resume) begin
                    st_nxt.mode = ST_RUN;
                    st_nxt.resume = 1'b1;
                    if (st_r.io_restart == mmss_pkg::IO_RESTART_REDO) begin
                        st_nxt.target = mmss_pkg::RES_IO_REDO;
                    end else if (st_r.halt_entry && st_r.halt_flag) begin
                        st_nxt.target = mmss_pkg::RES_HALT_AGAIN;
                        st_nxt.halt_fetch = 1'b1;
                    end else if (st_r.halt_entry) begin
                        st_nxt.target = mmss_pkg::RES_AFTER_HALT;
                    end else begin
                        st_nxt.target = mmss_pkg::RES_NORMAL;
                    end
                end else if (i_halt_instr) begin
                    st_nxt.mode = ST_MGMT_HALT;
                end
            end
            ST_MGMT_HALT: begin
                if (i_maskable_irq) begin
                    st_nxt.mode = ST_MGMT;
                end
            end
            default: begin
                st_nxt.mode = ST_RUN;
            end
        endcase
        if (i_sa_wr && st_r.mode != ST_RUN) begin
            if (i_sa_addr == mmss_pkg::OFS_HALT_RESTART) begin
                st_nxt.halt_flag = i_sa_wdata[0];
            end else if (i_sa_addr == mmss_pkg::OFS_IO_RESTART) begin
                st_nxt.io_restart = i_sa_wdata[7:0];
            end
        end
        if (i_sa_rd) begin
            case (i_sa_addr)
                mmss_pkg::OFS_REVISION: st_nxt.rdata = st_r.rev;
                mmss_pkg::OFS_HALT_RESTART: st_nxt.rdata = {31'h0, st_r.halt_flag};
                mmss_pkg::OFS_IO_RESTART: st_nxt.rdata = {24'h0, st_r.io_restart};
                mmss_pkg::OFS_IO_STATE: st_nxt.rdata = st_r.io_state;
                mmss_pkg::OFS_IO_MEM_ADDR: st_nxt.rdata = st_r.io_mem;
                default: st_nxt.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= '0;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // nmi handling
    // ------------------------------------------------------------
    mmss_nmi_gate u_nmi (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_enter(enter),
        .i_resume(resume),
        .i_intr_return(i_intr_return_instr),
        .i_nmi_req(i_nmi_req),
        .i_nmi_ack(i_nmi_ack),
        .i_in_nmi_handler(i_in_nmi_handler),
        .i_in_mgmt(st_r.mode != ST_RUN),
        .o_nmi_blocked(o_nmi_blocked),
        .o_nmi_take(o_nmi_take)
    );

    assign o_sa_rdata = st_r.rdata;
    assign o_in_mgmt = (st_r.mode != ST_RUN);
    assign o_halted_state = (st_r.mode == ST_MGMT_HALT);
    assign o_halt_fetch = st_r.halt_fetch;
    assign o_resume_target = st_r.target;
    assign o_resume_strobe = st_r.resume;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_rev_on_entry: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && enter |=> st_r.rev == rev_word)
        else $error("revision not written on entry");
    a_halt_flag_entry: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && enter |=> st_r.halt_flag == $past(i_halted))
        else $error("halt flag wrong on entry");
    a_io_restart_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && enter |=> st_r.io_restart == mmss_pkg::IO_RESTART_NONE)
        else $error("io restart not cleared on entry");
    a_valid_cause: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && enter && !st_r.io_last |=> !st_r.io_state[0])
        else $error("valid set without i/o");
    a_port_saved: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && enter && st_r.io_last && io_fields_ok
        |=> st_r.io_state[31:16] == $past(st_r.io_port) && st_r.io_state[0])
        else $error("port not saved");
    a_type_saved: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && enter && st_r.io_last && io_fields_ok
        |=> st_r.io_state[7:4] == $past(st_r.io_type))
        else $error("i/o type not saved");
    a_len_saved: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && enter && st_r.io_last && io_fields_ok
        |=> st_r.io_state[3:1] == $past(st_r.io_len))
        else $error("i/o length not saved");
    a_addr_saved: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && enter && st_r.io_last && io_fields_ok
        |=> st_r.io_mem == $past(st_r.io_addr))
        else $error("i/o memory address not saved");
    a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && enter |=> st_r.io_state[15:8] == 8'h00)
        else $error("reserved state bits not zero");
    a_state_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && i_sa_rd && i_sa_addr == mmss_pkg::OFS_IO_STATE
        |=> o_sa_rdata == $past(st_r.io_state))
        else $error("state word read wrong");
    a_flag_wr_refused: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && i_sa_wr && !o_in_mgmt && !enter
        |=> st_r.halt_flag == $past(st_r.halt_flag))
        else $error("halt flag written outside management mode");
    // ------------------------------------------------------------
    // exit checks, halt checks and covers
    // ------------------------------------------------------------
    a_resume_exit: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && resume |=> o_resume_strobe && !o_in_mgmt)
        else $error("resume did not leave management mode");
    a_halt_again: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && resume && st_r.halt_entry && st_r.halt_flag
        && st_r.io_restart != mmss_pkg::IO_RESTART_REDO
        |=> o_resume_target == mmss_pkg::RES_HALT_AGAIN && o_halt_fetch)
        else $error("halt not restarted");
    a_after_halt: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && resume && st_r.halt_entry && !st_r.halt_flag
        && st_r.io_restart != mmss_pkg::IO_RESTART_REDO
        |=> o_resume_target == mmss_pkg::RES_AFTER_HALT)
        else $error("wrong resume after cleared flag");
    a_normal_resume: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && resume && !st_r.halt_entry && st_r.io_restart != mmss_pkg::IO_RESTART_REDO
        |=> o_resume_target == mmss_pkg::RES_NORMAL && !o_halt_fetch)
        else $error("wrong resume without halt");
    a_io_redo: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && resume && st_r.io_restart == mmss_pkg::IO_RESTART_REDO
        |=> o_resume_target == mmss_pkg::RES_IO_REDO && !o_halt_fetch)
        else $error("trapped i/o not re-executed");
    a_fetch_only_halt: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && resume && !(st_r.halt_entry && st_r.halt_flag)
        |=> !o_halt_fetch)
        else $error("halt fetch without halt restart");
    a_halt_enter: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && o_in_mgmt && !o_halted_state && !resume && i_halt_instr
        |=> o_halted_state)
        else $error("halt in management mode not taken");
    a_halt_wakeup: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_ce && o_halted_state && !i_maskable_irq |=> o_halted_state)
        else $error("left halt without interrupt");
    c_io_trap: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        i_io_done ##1 enter);
    c_halt_resume: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        o_resume_strobe && o_halt_fetch);
    c_mgmt_halt: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        o_halted_state ##1 !o_halted_state);
endmodule : mmss_core
`default_nettype wire

//--- verification/mmss_core_tb.sv
// mmss_core_tb: self-checking bench for the management-mode state-save logic
// assumes: mmss_pkg and mmss_core compiled first, default parameters, one 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
module mmss_core_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic take = 1'b0, resume = 1'b0, intr_return_instr = 1'b0, halt_instr = 1'b0, mirq = 1'b0, halted = 1'b0;
    logic in_nmih = 1'b0, nreq = 1'b0, nack = 1'b0, io_done = 1'b0, sa_wr = 1'b0, sa_rd = 1'b0;
    logic [15:0] io_port = 16'h0000, sa_addr = 16'h0000;
    logic [3:0] io_type = 4'h0;
    logic [2:0] io_len = 3'h0;
    logic [31:0] io_addr = 32'h0, sa_wdata = 32'h0, sa_rdata;
    logic in_mgmt, halted_st, halt_fetch, res_strobe, nmi_blocked, nmi_take;
    logic [1:0] res_target;
    int err_count = 0;
    int samples_checked = 0;
    always #5 i_clk = ~i_clk;
    mmss_core dut (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(1'b1), .i_mgmt_irq_take(take),
        .i_resume_instr(resume), .i_intr_return_instr(intr_return_instr), .i_halt_instr(halt_instr),
        .i_maskable_irq(mirq), .i_halted(halted), .i_in_nmi_handler(in_nmih),
        .i_nmi_req(nreq), .i_nmi_ack(nack), .i_io_done(io_done), .i_io_port(io_port),
        .i_io_type(io_type), .i_io_len(io_len), .i_io_mem_addr(io_addr), .i_sa_wr(sa_wr),
        .i_sa_rd(sa_rd), .i_sa_addr(sa_addr), .i_sa_wdata(sa_wdata), .o_sa_rdata(sa_rdata),
        .o_in_mgmt(in_mgmt), .o_halted_state(halted_st), .o_halt_fetch(halt_fetch),
        .o_resume_target(res_target), .o_resume_strobe(res_strobe),
        .o_nmi_blocked(nmi_blocked), .o_nmi_take(nmi_take)
    );
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(posedge i_clk);
        sa_rd <= 1'b1;
        sa_addr <= a;
        @(posedge i_clk);
        sa_rd <= 1'b0;
        #1;
        chk(sa_rdata & m, exp, "save-area read");
    endtask : rd_chk
    task automatic sa_write(input logic [15:0] a, input logic [31:0] d);
        @(posedge i_clk);
        sa_wr <= 1'b1;
        sa_addr <= a;
        sa_wdata <= d;
        @(posedge i_clk);
        sa_wr <= 1'b0;
    endtask : sa_write
    // one-cycle pulses of {resume, maskable irq, halt, return, nmi req, nmi ack}
    task automatic ev(input logic [5:0] m);
        @(posedge i_clk);
        {resume, mirq, halt_instr, intr_return_instr, nreq, nack} <= m;
        @(posedge i_clk);
        {resume, mirq, halt_instr, intr_return_instr, nreq, nack} <= 6'h00;
        #1;
    endtask : ev
    task automatic enter(input logic io, input logic h, input logic nh);
        @(posedge i_clk);
        io_done <= io;
        halted <= h;
        in_nmih <= nh;
        @(posedge i_clk);
        io_done <= 1'b0;
        take <= 1'b1;
        @(posedge i_clk);
        take <= 1'b0;
        halted <= 1'b0;
        in_nmih <= 1'b0;
        #1;
        chk(in_mgmt, 32'h1, "entry");
        chk(nmi_blocked, 32'h1, "nmi blocked on entry");
        rd_chk(mmss_pkg::OFS_REVISION, 32'h0003_0001, 32'hffff_ffff);
        rd_chk(mmss_pkg::OFS_IO_RESTART, 32'h0, 32'hff);
        rd_chk(mmss_pkg::OFS_HALT_RESTART, {31'h0, h}, 32'h1);
    endtask : enter
    task automatic leave(input logic [1:0] t);
        ev(6'h20);
        chk(res_strobe, 32'h1, "resume strobe");
        chk(in_mgmt, 32'h0, "left mgmt");
        chk(res_target, t, "resume target");
        chk(halt_fetch, t == mmss_pkg::RES_HALT_AGAIN, "halt refetch");
    endtask : leave
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_io_types();
        logic [3:0] typ [8] = '{mmss_pkg::TYP_IN_IMM, mmss_pkg::TYP_IN_DX,
            mmss_pkg::TYP_OUT_IMM, mmss_pkg::TYP_OUT_DX, mmss_pkg::TYP_INS,
            mmss_pkg::TYP_OUTS, mmss_pkg::TYP_REP_INS, mmss_pkg::TYP_REP_OUTS};
        logic [2:0] len [3] = '{mmss_pkg::LEN_BYTE, mmss_pkg::LEN_WORD, mmss_pkg::LEN_DWORD};
        logic [31:0] w;
        for (int i = 0; i < 8; i++) begin
            @(posedge i_clk);
            io_port <= 16'hc0f0 + 16'(i);
            io_type <= typ[i];
            io_len <= len[i % 3];
            io_addr <= 32'h5a00_0000 + 32'(i);
            w = {16'hc0f0 + 16'(i), 8'h00, typ[i], len[i % 3], 1'b1};
            enter(1'b1, 1'b0, 1'b0);
            rd_chk(mmss_pkg::OFS_IO_STATE, w, 32'hffff_ffff);
            rd_chk(mmss_pkg::OFS_IO_MEM_ADDR, 32'h5a00_0000 + 32'(i), 32'hffff_ffff);
            sa_write(mmss_pkg::OFS_IO_STATE, 32'h0);
            rd_chk(mmss_pkg::OFS_IO_STATE, w, 32'hffff_ffff);
            leave(mmss_pkg::RES_NORMAL);
        end
        rd_chk(16'h7e00, 32'h0, 32'hffff_ffff);
    endtask : t_io_types
    task automatic t_no_io();
        enter(1'b0, 1'b0, 1'b0);
        rd_chk(mmss_pkg::OFS_IO_STATE, 32'h0, 32'h1);
        leave(mmss_pkg::RES_NORMAL);
    endtask : t_no_io
    task automatic t_halt();
        enter(1'b0, 1'b1, 1'b0);
        leave(mmss_pkg::RES_HALT_AGAIN);
        enter(1'b0, 1'b1, 1'b0);
        sa_write(mmss_pkg::OFS_HALT_RESTART, 32'h0);
        leave(mmss_pkg::RES_AFTER_HALT);
        enter(1'b0, 1'b0, 1'b0);
        sa_write(mmss_pkg::OFS_IO_RESTART, 32'hff);
        rd_chk(mmss_pkg::OFS_IO_RESTART, 32'hff, 32'hff);
        leave(mmss_pkg::RES_IO_REDO);
        enter(1'b0, 1'b0, 1'b0);
        ev(6'h08);
        chk(halted_st, 32'h1, "halted in mgmt");
        ev(6'h20);
        chk(in_mgmt, 32'h1, "resume while halted");
        chk(halted_st, 32'h1, "still halted");
        ev(6'h10);
        chk(halted_st, 32'h0, "woken by maskable irq");
        leave(mmss_pkg::RES_NORMAL);
    endtask : t_halt
    task automatic t_nmi();
        enter(1'b0, 1'b0, 1'b0);
        ev(6'h02);
        ev(6'h02);
        chk(nmi_take, 32'h0, "nmi held in mgmt");
        leave(mmss_pkg::RES_NORMAL);
        chk(nmi_blocked, 32'h0, "nmi unblocked on exit");
        chk(nmi_take, 32'h1, "pending nmi taken");
        ev(6'h01);
        chk(nmi_take, 32'h0, "only one nmi latched");
        chk(nmi_blocked, 32'h1, "serviced nmi blocks nmi");
        enter(1'b0, 1'b0, 1'b0);
        ev(6'h04);
        chk(nmi_blocked, 32'h0, "return unblocks nmi");
        leave(mmss_pkg::RES_NORMAL);
        chk(nmi_blocked, 32'h1, "blocking kept after resume");
        enter(1'b0, 1'b0, 1'b1);
        ev(6'h02);
        leave(mmss_pkg::RES_NORMAL);
        chk(nmi_blocked, 32'h0, "nmi handler entry");
        chk(nmi_take, 32'h1, "nested nmi taken");
        ev(6'h01);
        ev(6'h04);
        chk(nmi_blocked, 32'h0, "return ends nmi handler");
    endtask : t_nmi
    // ------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic results();
        $display("checks made %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    initial begin
        #100000;
        err_count++;
        results();
    end
    initial begin
        repeat (3) @(posedge i_clk);
        #1;
        chk({in_mgmt, halted_st, halt_fetch, res_strobe, nmi_blocked, nmi_take}, 32'h0,
            "reset");
        @(posedge i_clk);
        i_arst_n <= 1'b1;
        t_io_types();
        t_no_io();
        t_halt();
        t_nmi();
        results();
    end
endmodule : mmss_core_tb
`default_nettype wire
